/* src/svlm_pkg.sv */
package svlm_pkg;

  localparam int LANES = 16;
  localparam int LANE_W = 4;
  localparam int VID_W = 8;
  localparam int RET_W = 4;
  localparam logic [3:0] MAX_LANE = 4'hF;

  // normal-order receive lanes of the return signals
  localparam logic [3:0] RX_LANE_TV = 4'h0;
  localparam logic [3:0] RX_LANE_B_IRQ = 4'h1;
  localparam logic [3:0] RX_LANE_STALL = 4'h2;
  localparam logic [3:0] RX_LANE_C_IRQ = 4'h5;

  // position of channel C red in the transmit vector
  localparam int CHAN_C_RED_IDX = 4;

  // strap levels
  localparam logic STRAP_REVERSE_LEVEL = 1'b0;
  localparam logic STRAP_CONCURRENT_LEVEL = 1'b1;

  // strap settle time before the configuration is latched
  localparam int SYS_PERIOD_NS = 100;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int SETTLE_W = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST =
    SETTLE_W'(STRAP_SETTLE_CYC - 1);

  typedef enum logic [1:0]
  {
    SVLM_VIDEO_NORMAL,
    SVLM_VIDEO_REVERSED,
    SVLM_CONC_NORMAL,
    SVLM_CONC_REVERSED
  } svlm_mode_e;

  typedef enum logic
  {
    SVLM_CFG_WAIT,
    SVLM_CFG_LOCKED
  } svlm_cfg_e;

  // bit 0 is channel B red
  typedef struct packed {
    logic chan_c_fwd_clock;
    logic chan_c_blue_pair;
    logic chan_c_green_pair;
    logic chan_c_red_pair;
    logic chan_b_fwd_clock;
    logic chan_b_blue_pair;
    logic chan_b_green_pair;
    logic chan_b_red_pair;
  } svlm_video_s;

  // bit 0 is the tv sync clock
  typedef struct packed {
    logic chan_c_irq_in;
    logic field_stall_in;
    logic chan_b_irq_in;
    logic tv_sync_clock_in;
  } svlm_return_s;

  // lane sets counted from the high end
  function automatic logic uses_high_set(svlm_mode_e mode);
    uses_high_set = (mode == SVLM_VIDEO_REVERSED) ||
                    (mode == SVLM_CONC_NORMAL);
  endfunction

  function automatic logic [3:0] lane_of(logic high_set, logic [3:0] idx);
    lane_of = high_set ? (MAX_LANE - idx) : idx;
  endfunction

endpackage

/* src/svlm_cfg_cross.sv */
`timescale 1ns/1ps
`default_nettype none

module svlm_cfg_cross
(
  input wire logic clk_link,
  input wire logic rst_link_n,
  input wire logic src_locked,
  input wire svlm_pkg::svlm_mode_e src_mode,
  output logic dst_locked,
  output svlm_pkg::svlm_mode_e dst_mode
);

  logic lock_meta;
  logic lock_sync;

  // lock level into the link domain
  always_ff @(posedge clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end
    else
    begin
      lock_meta <= src_locked;
      lock_sync <= lock_meta;
    end
  end

  // mode is stable before the lock is seen, so it is taken once
  always_ff @(posedge clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      dst_locked <= 1'b0;
      dst_mode <= svlm_pkg::SVLM_VIDEO_NORMAL;
    end
    else if (lock_sync && !dst_locked)
    begin
      dst_locked <= 1'b1;
      dst_mode <= src_mode;
    end
  end

endmodule

`default_nettype wire

/* src/svlm_lane_mux.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - video pins shared with graphics lane pins
// - control wires bypass the lane multiplexer
// - no graphics port: video on own pins
// - four lane assignments chosen by straps
// - integrated-only parts never reverse lanes
// - video-only normal: B lanes 0-3, C 4-7
// - high set: B lanes 15-12, C 11-8
// - concurrent reversed uses low lane set
// - low set receive: lanes 0,1,2,5
// - high set receive: lanes 15,14,13,10
// - forwarded clock per channel; C red alpha
// - control wires open drain, released high
// - reverse strap low means reversed
// - concurrency strap high means concurrent
module svlm_lane_mux
#(
  parameter bit HAS_GFX_PORT = 1'b1,
  parameter bit IGD_ONLY = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic lane_reverse_strap,
  input wire logic concurrent_strap,
  input wire svlm_pkg::svlm_video_s video_tx,
  input wire logic chan_b_alpha,
  input wire logic alpha_on_c_red,
  input wire logic [15:0] pcie_tx_p,
  input wire logic [15:0] pcie_tx_n,
  output logic [15:0] lane_tx_p,
  output logic [15:0] lane_tx_n,
  output logic [7:0] own_tx_p,
  output logic [7:0] own_tx_n,
  input wire logic [15:0] lane_rx_p,
  input wire logic [15:0] lane_rx_n,
  input wire logic [3:0] own_rx_p,
  input wire logic [3:0] own_rx_n,
  output svlm_pkg::svlm_return_s video_rx,
  output logic [3:0] video_rx_fault,
  input wire logic ctl_clock_pull,
  input wire logic ctl_data_pull,
  input wire logic video_ctl_clock_in,
  output logic video_ctl_clock_out,
  output logic video_ctl_clock_oe_n,
  input wire logic video_ctl_data_in,
  output logic video_ctl_data_out,
  output logic video_ctl_data_oe_n,
  output logic ctl_clock_level,
  output logic ctl_data_level,
  output logic cfg_locked,
  output svlm_pkg::svlm_mode_e cfg_mode,
  output logic link_locked
);

  // strap synchronisers
  logic rev_meta;
  logic rev_sync;
  logic conc_meta;
  logic conc_sync;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rev_meta <= 1'b1;
      rev_sync <= 1'b1;
      conc_meta <= 1'b0;
      conc_sync <= 1'b0;
    end
    else
    begin
      rev_meta <= lane_reverse_strap;
      rev_sync <= rev_meta;
      conc_meta <= concurrent_strap;
      conc_sync <= conc_meta;
    end
  end

  // mode decode from synchronised straps
  logic want_reverse;
  logic want_concurrent;
  svlm_pkg::svlm_mode_e next_mode;

  always_comb
  begin
    want_reverse = (rev_sync == svlm_pkg::STRAP_REVERSE_LEVEL) &&
                   !IGD_ONLY;
    want_concurrent = (conc_sync == svlm_pkg::STRAP_CONCURRENT_LEVEL) &&
                      HAS_GFX_PORT;
    unique case ({want_concurrent, want_reverse})
      2'b00: next_mode = svlm_pkg::SVLM_VIDEO_NORMAL;
      2'b01: next_mode = svlm_pkg::SVLM_VIDEO_REVERSED;
      2'b10: next_mode = svlm_pkg::SVLM_CONC_NORMAL;
      2'b11: next_mode = svlm_pkg::SVLM_CONC_REVERSED;
    endcase
  end

  // configuration sampling: wait for straps to settle, then lock
  svlm_pkg::svlm_cfg_e cfg_state;
  logic [svlm_pkg::SETTLE_W-1:0] settle_cnt;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_state <= svlm_pkg::SVLM_CFG_WAIT;
      settle_cnt <= '0;
      cfg_mode <= svlm_pkg::SVLM_VIDEO_NORMAL;
    end
    else
    begin
      unique case (cfg_state)
        svlm_pkg::SVLM_CFG_WAIT:
        begin
          if (settle_cnt == svlm_pkg::SETTLE_LAST)
          begin
            cfg_mode <= next_mode;
            cfg_state <= svlm_pkg::SVLM_CFG_LOCKED;
          end
          else
          begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
        svlm_pkg::SVLM_CFG_LOCKED:
        begin
          cfg_state <= svlm_pkg::SVLM_CFG_LOCKED;
        end
      endcase
    end
  end

  assign cfg_locked = (cfg_state == svlm_pkg::SVLM_CFG_LOCKED);

  // link domain reset: asserted at once, released on the link clock
  logic link_rst_meta;
  logic link_rst_n;

  always_ff @(posedge clk_link or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_rst_meta <= 1'b0;
      link_rst_n <= 1'b0;
    end
    else
    begin
      link_rst_meta <= 1'b1;
      link_rst_n <= link_rst_meta;
    end
  end

  // carry the locked mode over to the link domain
  svlm_pkg::svlm_mode_e link_mode;

  svlm_cfg_cross u_cfg_cross
  (
    .clk_link(clk_link),
    .rst_link_n(link_rst_n),
    .src_locked(cfg_locked),
    .src_mode(cfg_mode),
    .dst_locked(link_locked),
    .dst_mode(link_mode)
  );

  // transmit routing in the link domain
  logic [svlm_pkg::VID_W-1:0] vid_vec;
  logic link_high_set;
  logic link_concurrent;

  always_comb
  begin
    vid_vec = svlm_pkg::VID_W'(video_tx);
    if (alpha_on_c_red)
    begin
      vid_vec[svlm_pkg::CHAN_C_RED_IDX] = chan_b_alpha;
    end
    link_high_set = svlm_pkg::uses_high_set(link_mode);
    link_concurrent = (link_mode == svlm_pkg::SVLM_CONC_NORMAL) ||
                      (link_mode == svlm_pkg::SVLM_CONC_REVERSED);
  end

  logic [15:0] next_tx_p;
  logic [15:0] next_tx_n;

  genvar gl;
  generate
    for (gl = 0; gl < svlm_pkg::LANES; gl = gl + 1)
    begin : g_tx_lane
      logic [3:0] src_idx;
      logic is_video;
      always_comb
      begin
        // lane to channel signal, the inverse of the same mapping
        src_idx = svlm_pkg::lane_of(link_high_set,
                                    4'(gl));
        is_video = (src_idx < 4'(svlm_pkg::VID_W));
        if (is_video)
        begin
          next_tx_p[gl] = vid_vec[src_idx[2:0]];
          next_tx_n[gl] = !vid_vec[src_idx[2:0]];
        end
        else if (link_concurrent)
        begin
          next_tx_p[gl] = pcie_tx_p[gl];
          next_tx_n[gl] = pcie_tx_n[gl];
        end
        else
        begin
          next_tx_p[gl] = 1'b0;
          next_tx_n[gl] = 1'b0;
        end
      end
    end
  endgenerate

  // lanes stay idle until the mode is known on the link side
  always_ff @(posedge clk_link or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      lane_tx_p <= '0;
      lane_tx_n <= '0;
      own_tx_p <= '0;
      own_tx_n <= '0;
    end
    else if (!link_locked)
    begin
      lane_tx_p <= '0;
      lane_tx_n <= '0;
      own_tx_p <= '0;
      own_tx_n <= '0;
    end
    else if (HAS_GFX_PORT)
    begin
      lane_tx_p <= next_tx_p;
      lane_tx_n <= next_tx_n;
      own_tx_p <= '0;
      own_tx_n <= '0;
    end
    else
    begin
      lane_tx_p <= '0;
      lane_tx_n <= '0;
      own_tx_p <= vid_vec;
      own_tx_n <= ~vid_vec;
    end
  end

  // receive pins into the system domain
  logic [15:0] rxp_meta;
  logic [15:0] rxp_sync;
  logic [15:0] rxn_meta;
  logic [15:0] rxn_sync;
  logic [3:0] own_p_meta;
  logic [3:0] own_p_sync;
  logic [3:0] own_n_meta;
  logic [3:0] own_n_sync;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxp_meta <= '0;
      rxp_sync <= '0;
      rxn_meta <= '0;
      rxn_sync <= '0;
      own_p_meta <= '0;
      own_p_sync <= '0;
      own_n_meta <= '0;
      own_n_sync <= '0;
    end
    else
    begin
      rxp_meta <= lane_rx_p;
      rxp_sync <= rxp_meta;
      rxn_meta <= lane_rx_n;
      rxn_sync <= rxn_meta;
      own_p_meta <= own_rx_p;
      own_p_sync <= own_p_meta;
      own_n_meta <= own_rx_n;
      own_n_sync <= own_n_meta;
    end
  end

  // pick each return signal's pair from its lane, or from the own pins without a graphics port
  logic sys_high_set;
  logic [3:0] ret_p;
  logic [3:0] ret_n;
  logic [3:0] ret_lane [svlm_pkg::RET_W];

  always_comb
  begin
    sys_high_set = svlm_pkg::uses_high_set(cfg_mode);
    ret_lane[0] = svlm_pkg::lane_of(sys_high_set,
                                    svlm_pkg::RX_LANE_TV);
    ret_lane[1] = svlm_pkg::lane_of(sys_high_set,
                                    svlm_pkg::RX_LANE_B_IRQ);
    ret_lane[2] = svlm_pkg::lane_of(sys_high_set,
                                    svlm_pkg::RX_LANE_STALL);
    ret_lane[3] = svlm_pkg::lane_of(sys_high_set,
                                    svlm_pkg::RX_LANE_C_IRQ);
  end

  genvar gr;
  generate
    for (gr = 0; gr < svlm_pkg::RET_W; gr = gr + 1)
    begin : g_rx_sel
      always_comb
      begin
        if (HAS_GFX_PORT)
        begin
          ret_p[gr] = rxp_sync[ret_lane[gr]];
          ret_n[gr] = rxn_sync[ret_lane[gr]];
        end
        else
        begin
          ret_p[gr] = own_p_sync[gr];
          ret_n[gr] = own_n_sync[gr];
        end
      end
    end
  endgenerate

  // a pair with both wires equal is not a valid level: hold last value
  logic [3:0] ret_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ret_q <= '0;
      video_rx_fault <= '0;
    end
    else if (!cfg_locked)
    begin
      ret_q <= '0;
      video_rx_fault <= '0;
    end
    else
    begin
      for (int i = 0; i < svlm_pkg::RET_W; i++)
      begin
        if (ret_p[i] != ret_n[i])
        begin
          ret_q[i] <= ret_p[i];
        end
        video_rx_fault[i] <= (ret_p[i] == ret_n[i]);
      end
    end
  end

  assign video_rx = svlm_pkg::svlm_return_s'(ret_q);

  // control wires on dedicated pins, never through the lane mux
  logic clk_pin_meta;
  logic clk_pin_sync;
  logic dat_pin_meta;
  logic dat_pin_sync;

  assign video_ctl_clock_out = 1'b0;
  assign video_ctl_data_out = 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      video_ctl_clock_oe_n <= 1'b1;
      video_ctl_data_oe_n <= 1'b1;
    end
    else
    begin
      video_ctl_clock_oe_n <= !ctl_clock_pull;
      video_ctl_data_oe_n <= !ctl_data_pull;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_pin_meta <= 1'b1;
      clk_pin_sync <= 1'b1;
      dat_pin_meta <= 1'b1;
      dat_pin_sync <= 1'b1;
    end
    else
    begin
      clk_pin_meta <= video_ctl_clock_in;
      clk_pin_sync <= clk_pin_meta;
      dat_pin_meta <= video_ctl_data_in;
      dat_pin_sync <= dat_pin_meta;
    end
  end

  assign ctl_clock_level = clk_pin_sync;
  assign ctl_data_level = dat_pin_sync;

endmodule

`default_nettype wire

/* tb/svlm_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module svlm_chk
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic lane_reverse_strap,
  input wire logic concurrent_strap,
  input wire svlm_pkg::svlm_video_s video_tx,
  input wire logic [15:0] lane_tx_p,
  input wire logic [15:0] lane_tx_n,
  input wire logic [15:0] lane_rx_p,
  input wire logic [15:0] lane_rx_n,
  input wire svlm_pkg::svlm_return_s video_rx,
  input wire logic ctl_clock_pull,
  input wire logic video_ctl_clock_out,
  input wire logic video_ctl_clock_oe_n,
  input wire logic cfg_locked,
  input wire svlm_pkg::svlm_mode_e cfg_mode,
  input wire logic link_locked
);
  logic hi;
  logic lk2;
  // lanes counted from the high end
  assign hi = (cfg_mode == svlm_pkg::SVLM_VIDEO_REVERSED) ||
    (cfg_mode == svlm_pkg::SVLM_CONC_NORMAL);
  property p_low_tx;
    @(posedge clk_link) disable iff (!rst_n)
    link_locked && $past(link_locked) && !hi |=>
      {lane_tx_p[7], lane_tx_p[3:0]} == $past({video_tx[7], video_tx[3:0]});
  endproperty
  a_low_tx: assert property (p_low_tx) else $error("low set tx");
  property p_high_tx;
    @(posedge clk_link) disable iff (!rst_n)
    link_locked && $past(link_locked) && hi |=>
      {lane_tx_p[8], lane_tx_p[12], lane_tx_p[13], lane_tx_p[14],
      lane_tx_p[15]} == $past({video_tx[7], video_tx[3:0]});
  endproperty
  a_high_tx: assert property (p_high_tx) else $error("high set tx");
  property p_pair;
    @(posedge clk_link) disable iff (!rst_n)
    link_locked && $past(link_locked) |=>
      (hi ? lane_tx_n[15:8] : lane_tx_n[7:0]) ==
      ~(hi ? lane_tx_p[15:8] : lane_tx_p[7:0]);
  endproperty
  a_pair: assert property (p_pair) else $error("pair not complement");
  property p_idle;
    @(posedge clk_link) disable iff (!rst_n)
    !link_locked |-> lane_tx_p == 16'h0000 && lane_tx_n == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes before lock");
  property p_rx_lo;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg_locked && !hi && lane_rx_p[1] != lane_rx_n[1] |->
      ##3 video_rx.chan_b_irq_in == $past(lane_rx_p[1], 3);
  endproperty
  a_rx_lo: assert property (p_rx_lo) else $error("low set rx");
  property p_rx_hi;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg_locked && hi && lane_rx_p[15] != lane_rx_n[15] |->
      ##3 video_rx.tv_sync_clock_in == $past(lane_rx_p[15], 3);
  endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("high set rx");
  property p_oe;
    @(posedge clk_sys) disable iff (!rst_n)
    video_ctl_clock_oe_n == !$past(ctl_clock_pull) && !video_ctl_clock_out;
  endproperty
  a_oe: assert property (p_oe) else $error("control clock drive");
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    cfg_locked |=> cfg_locked && $stable(cfg_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  property p_strap;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(cfg_locked) |->
      cfg_mode == {concurrent_strap, ~lane_reverse_strap};
  endproperty
  a_strap: assert property (p_strap) else $error("strap mode");
  always_ff @(posedge clk_link)
  begin
    lk2 <= link_locked;
  end
  c_hi: cover property (@(posedge clk_link) lk2 && hi);
  c_lo: cover property (@(posedge clk_link) lk2 && !hi);
  c_pull: cover property (@(posedge clk_sys) !video_ctl_clock_oe_n);
endmodule
bind svlm_lane_mux svlm_chk chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
  .lane_reverse_strap(lane_reverse_strap),
  .concurrent_strap(concurrent_strap), .video_tx(video_tx),
  .lane_tx_p(lane_tx_p), .lane_tx_n(lane_tx_n),
  .lane_rx_p(lane_rx_p), .lane_rx_n(lane_rx_n), .video_rx(video_rx),
  .ctl_clock_pull(ctl_clock_pull),
  .video_ctl_clock_out(video_ctl_clock_out),
  .video_ctl_clock_oe_n(video_ctl_clock_oe_n),
  .cfg_locked(cfg_locked), .cfg_mode(cfg_mode), .link_locked(link_locked)
);
`default_nettype wire

/* tb/svlm_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module svlm_enc_model
(
  input wire logic high_set,
  input wire svlm_pkg::svlm_return_s ret,
  input wire logic bad_pair,
  input wire logic dev_clk_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic enc_clk_pull,
  input wire logic enc_data_pull,
  output logic [15:0] rx_p,
  output logic [15:0] rx_n,
  output logic ctl_clk_wire,
  output logic ctl_data_wire
);
  localparam logic [3:0] base [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
  logic [3:0] k;
  // each return signal as a differential pair, except signal 1 with equal wires under bad_pair
  always_comb
  begin
    rx_p = 16'h0000;
    rx_n = 16'hFFFF;
    k = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      k = high_set ? 4'hF - base[i] : base[i];
      rx_p[k] = ret[i];
      rx_n[k] = ~ret[i] ^ (bad_pair && i == 1);
    end
  end
  // open drain wires with pull-up
  assign ctl_clk_wire = dev_clk_oe_n && !enc_clk_pull;
  assign ctl_data_wire = dev_data_oe_n && !enc_data_pull;
endmodule
`default_nettype wire

/* tb/svlm_lane_mux_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module svlm_lane_mux_tb;
  logic clk_sys, clk_link, rst_n, rev_s, conc_s, a_on, b_al, bad, hs;
  logic ck_pull, dt_pull, enc_pull, ck_oe_n, dt_oe_n, ck_w, dt_w;
  logic ck_lvl, dt_lvl, locked, lk, ck_out, dt_out;
  logic [7:0] ot_p, ot_n;
  svlm_pkg::svlm_video_s vtx;
  svlm_pkg::svlm_return_s ret, vrx;
  svlm_pkg::svlm_mode_e mode;
  logic [15:0] pp, pn, tx_p, tx_n, rx_p, rx_n;
  logic [3:0] fault;
  int errors, checked;
  svlm_lane_mux uut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .lane_reverse_strap(rev_s), .concurrent_strap(conc_s),
    .video_tx(vtx), .chan_b_alpha(b_al), .alpha_on_c_red(a_on),
    .pcie_tx_p(pp), .pcie_tx_n(pn), .lane_tx_p(tx_p), .lane_tx_n(tx_n),
    .own_tx_p(ot_p), .own_tx_n(ot_n), .lane_rx_p(rx_p), .lane_rx_n(rx_n),
    .own_rx_p(4'h0), .own_rx_n(4'hF), .video_rx(vrx),
    .video_rx_fault(fault), .ctl_clock_pull(ck_pull),
    .ctl_data_pull(dt_pull), .video_ctl_clock_in(ck_w),
    .video_ctl_clock_out(ck_out), .video_ctl_clock_oe_n(ck_oe_n),
    .video_ctl_data_in(dt_w), .video_ctl_data_out(dt_out),
    .video_ctl_data_oe_n(dt_oe_n), .ctl_clock_level(ck_lvl),
    .ctl_data_level(dt_lvl), .cfg_locked(locked), .cfg_mode(mode),
    .link_locked(lk)
  );
  svlm_enc_model enc
  (
    .high_set(hs), .ret(ret), .bad_pair(bad), .dev_clk_oe_n(ck_oe_n),
    .dev_data_oe_n(dt_oe_n), .enc_clk_pull(1'b0),
    .enc_data_pull(enc_pull), .rx_p(rx_p), .rx_n(rx_n),
    .ctl_clk_wire(ck_w), .ctl_data_wire(dt_w)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = ~clk_link;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task boot(input logic [1:0] m);
    int n;
    n = 0;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    conc_s <= m[1];
    rev_s <= ~m[0];
    hs <= m[0] ^ m[1];
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    while (lk !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({14'h0000, lk, locked}, 16'h0003);
    check({14'h0000, mode}, {14'h0000, m});
  endtask
  task tx_route(input logic [1:0] m);
    logic [15:0] ep, en;
    @(posedge clk_link);
    vtx <= 8'h2D;
    repeat (3) @(posedge clk_link);
    ep = m[1] ? pp : 16'h0000;
    en = m[1] ? pn : 16'h0000;
    for (int k = 0; k < 8; k++)
    begin
      ep[(m[0] ^ m[1]) ? 15 - k : k] = vtx[k];
      en[(m[0] ^ m[1]) ? 15 - k : k] = ~vtx[k];
    end
    check(tx_p, ep);
    check(tx_n, en);
    check({ot_p, ot_n}, 16'h0000);
  endtask
  task rx_route(input logic [1:0] m);
    ret <= 4'hA;
    repeat (6) @(posedge clk_sys);
    check({12'h000, vrx}, 16'h000A);
    ret <= 4'h5;
    repeat (6) @(posedge clk_sys);
    check({12'h000, vrx}, 16'h0005);
    conc_s <= ~m[1];
    rev_s <= m[0];
    repeat (20) @(posedge clk_sys);
    check({14'h0000, mode}, {14'h0000, m});
  endtask
  task alpha_and_fault;
    @(posedge clk_link);
    b_al <= 1'b1;
    a_on <= 1'b1;
    vtx <= 8'h00;
    repeat (3) @(posedge clk_link);
    // last mode is concurrent: upper lanes carry the pcie pattern
    check(tx_p, {pp[15:8], 8'h10});
    @(posedge clk_sys);
    bad <= 1'b1;
    ret <= 4'hF;
    repeat (6) @(posedge clk_sys);
    check({8'h00, fault, vrx}, 16'h002D);
    bad <= 1'b0;
  endtask
  task ctl_wires;
    @(posedge clk_sys);
    ck_pull <= 1'b1;
    enc_pull <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check({12'h000, ck_oe_n, dt_oe_n, ck_lvl, dt_lvl}, 16'h0004);
    check({14'h0000, ck_out, dt_out}, 16'h0000);
    ck_pull <= 1'b0;
    enc_pull <= 1'b0;
    dt_pull <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check({12'h000, ck_oe_n, dt_oe_n, ck_lvl, dt_lvl}, 16'h000A);
  endtask
  initial
  begin
    {rst_n, rev_s, conc_s, a_on, b_al, bad, hs} = 7'h00;
    {ck_pull, dt_pull, enc_pull} = 3'h0;
    vtx = 8'h00;
    ret = 4'h0;
    pp = 16'h5A3C;
    pn = 16'h0F96;
    errors = 0;
    checked = 0;
    for (int i = 0; i < 4; i++)
    begin
      boot(2'(i));
      tx_route(2'(i));
      rx_route(2'(i));
    end
    alpha_and_fault;
    ctl_wires;
    wrap_up;
  end
  initial
  begin
    #200000;
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
